// ### logic/acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// control word field positions on the data lines
`define ACS_CODING_BIT   0
`define ACS_RANGE_BIT    1
`define ACS_MASK_SEL_BIT 2
`define ACS_SEQ_EN_BIT   3
`define ACS_PWR_LO_BIT   4
`define ACS_PWR_HI_BIT   5
`define ACS_CFG_A_BIT    6
`define ACS_CFG_B_BIT    7
`define ACS_ADD_LSB      8
`define ACS_ADD_MSB      10

`define ACS_MASK_RESET   8'h00
`define ACS_PAIR_SEL     8'h55
`define ACS_NO_REF7_SEL  8'h7f
`define ACS_CFG_SINGLE   2'h0
`define ACS_CFG_DIFF     2'h1
`define ACS_CFG_PSEUDO4  2'h2
`define ACS_CFG_PSEUDO7  2'h3
`define ACS_REF_CHANNEL  3'h7
`define ACS_CONV_PERIODS 4'hd

`endif

// ### logic/acs_pkg.sv
`default_nettype none
package acs_pkg;
  typedef struct packed {
    logic [1:0] power_mode;
    logic [1:0] input_config;
    logic       range_2x;
    logic       twos_complement;
    logic [2:0] channel_addr;
  } acs_ctrl_s;

  typedef enum logic [1:0] {
    ACS_SEQ_OFF,
    ACS_SEQ_MASK,
    ACS_SEQ_CONSEC
  } acs_seq_e;

  typedef enum logic {
    ACS_CV_IDLE,
    ACS_CV_RUN
  } acs_cv_e;
endpackage
`default_nettype wire

// ### logic/acs_sequencer.sv
// Functional notes
// - channel mask is an 8-bit register, writable, never readable
// - write strobe rising edge captures data lines 0..7 into the mask
// - mask loads only if previous control write had sequence 0, select 1
// - mask bit n selects analog input n, bit 7 most significant
// - each convert-start fall converts next selected channel, ascending, cyclic
// - control write with sequence 0 stops sequencing; sequence 1, select 1 restarts consecutive scan from 0
// - paired modes sequence pairs in normal polarity; an odd address converted directly (no sequence or none selected) is reversed
// - range bit 0 gives one reference span, 1 gives twice
// - coding bit selects straight binary or twos complement results
// - codes step per LSB of reference over 4096 or 2048
// - two power-mode bits from control write select power behaviour
// - inputs disconnected from conversion start until code is produced
// - control write with sequence 1, select 0 keeps sequence running
// - two config bits: single, differential, pseudo pairs, seven pseudo
// - conversion needs 13 conversion clock periods, else it aborts
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"

module acs_sequencer #(
  parameter int DATA_W  = 12,
  parameter int RES_BITS = 12
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                write_strobe_n,
  input  wire logic [DATA_W-1:0]   data_lines,
  input  wire logic                convert_start_n,
  input  wire logic                conversion_clock_input,
  input  wire logic [RES_BITS-1:0] sar_code,
  output logic                     inputs_connected,
  output logic                     conv_busy,
  output logic                     conv_done,
  output logic                     conv_aborted,
  output logic [2:0]               pos_channel,
  output logic [2:0]               neg_channel,
  output logic                     neg_is_ground,
  output logic [RES_BITS-1:0]      conv_result,
  output acs_pkg::acs_ctrl_s       ctrl_out,
  output logic                     seq_running
);

  // scan upward from start for the first selected channel, wrapping
  function automatic logic [3:0] next_sel(input logic [7:0] sel, input logic [2:0] start);
    logic [2:0] idx;
    next_sel = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      idx = start + 3'(i);
      if (sel[idx]) begin
        next_sel = {1'b1, idx};
      end
    end
  endfunction

  // negative input that goes with a positive channel
  function automatic logic [2:0] neg_of(input logic [1:0] cfg, input logic [2:0] ch);
    neg_of = (cfg == `ACS_CFG_PSEUDO7) ? `ACS_REF_CHANNEL : (ch ^ 3'h1);
  endfunction

  // two-stage synchronisers for the strobe, start, clock and data inputs
  logic [1:0]        wr_sync_reg;
  logic [1:0]        cs_sync_reg;
  logic [1:0]        ck_sync_reg;
  logic [DATA_W-1:0] db_meta_reg;
  logic [DATA_W-1:0] db_sync_reg;
  logic              wr_last_reg;
  logic              cs_last_reg;
  logic              ck_last_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_sync_reg <= 2'h3;
      cs_sync_reg <= 2'h3;
      ck_sync_reg <= 2'h0;
      db_meta_reg <= '0;
      db_sync_reg <= '0;
      wr_last_reg <= 1'b1;
      cs_last_reg <= 1'b1;
      ck_last_reg <= 1'b0;
    end else begin
      wr_sync_reg <= {wr_sync_reg[0], write_strobe_n};
      cs_sync_reg <= {cs_sync_reg[0], convert_start_n};
      ck_sync_reg <= {ck_sync_reg[0], conversion_clock_input};
      db_meta_reg <= data_lines;
      db_sync_reg <= db_meta_reg;
      wr_last_reg <= wr_sync_reg[1];
      cs_last_reg <= cs_sync_reg[1];
      ck_last_reg <= ck_sync_reg[1];
    end
  end

  logic wr_rise;
  logic cs_fall;
  logic ck_rise;
  assign wr_rise = wr_sync_reg[1] & ~wr_last_reg;
  assign cs_fall = ~cs_sync_reg[1] & cs_last_reg;
  assign ck_rise = ck_sync_reg[1] & ~ck_last_reg;

  // control, mask and sequencer position
  acs_pkg::acs_ctrl_s ctrl_reg, ctrl_next;
  acs_pkg::acs_seq_e  mode_reg, mode_next;
  logic [7:0]         mask_reg, mask_next;
  logic               armed_reg, armed_next;
  logic [2:0]         seqpos_reg, seqpos_next;
  logic [7:0]         sel;
  logic [3:0]         pick;
  logic [2:0]         chan;
  logic               paired;
  logic               seq_en;
  logic               mask_sel;

  always_comb begin
    ctrl_next   = ctrl_reg;
    mode_next   = mode_reg;
    mask_next   = mask_reg;
    armed_next  = armed_reg;
    seqpos_next = seqpos_reg;
    seq_en      = db_sync_reg[`ACS_SEQ_EN_BIT];
    mask_sel    = db_sync_reg[`ACS_MASK_SEL_BIT];
    paired      = (ctrl_reg.input_config == `ACS_CFG_DIFF) ||
                  (ctrl_reg.input_config == `ACS_CFG_PSEUDO4);
    if (mode_reg == acs_pkg::ACS_SEQ_CONSEC) begin
      sel = 8'((9'h2 << ctrl_reg.channel_addr) - 9'h1);
    end else begin
      sel = mask_reg;
    end
    if (paired) begin
      sel = sel & `ACS_PAIR_SEL;
    end
    if (ctrl_reg.input_config == `ACS_CFG_PSEUDO7) begin
      sel = sel & `ACS_NO_REF7_SEL;
    end
    pick = next_sel(sel, seqpos_reg);
    chan = (mode_reg == acs_pkg::ACS_SEQ_OFF || !pick[3]) ? ctrl_reg.channel_addr : pick[2:0];
    if (wr_rise) begin
      if (armed_reg) begin
        mask_next   = db_sync_reg[7:0];
        armed_next  = 1'b0;
        mode_next   = acs_pkg::ACS_SEQ_MASK;
        seqpos_next = 3'h0;
      end else begin
        ctrl_next.twos_complement = db_sync_reg[`ACS_CODING_BIT];
        ctrl_next.range_2x        = db_sync_reg[`ACS_RANGE_BIT];
        ctrl_next.power_mode      = {db_sync_reg[`ACS_PWR_HI_BIT],
                                     db_sync_reg[`ACS_PWR_LO_BIT]};
        // config code is {a, b}: 01 differential pairs, 10 pseudo pairs
        ctrl_next.input_config    = {db_sync_reg[`ACS_CFG_A_BIT],
                                     db_sync_reg[`ACS_CFG_B_BIT]};
        ctrl_next.channel_addr    = db_sync_reg[`ACS_ADD_MSB:`ACS_ADD_LSB];
        armed_next = !seq_en && mask_sel;
        if (seq_en && mask_sel) begin
          mode_next   = acs_pkg::ACS_SEQ_CONSEC;
          seqpos_next = 3'h0;
        end else if (!(seq_en && !mask_sel)) begin
          mode_next = acs_pkg::ACS_SEQ_OFF;
        end
      end
    end else if (cs_fall && mode_reg != acs_pkg::ACS_SEQ_OFF && pick[3]) begin
      seqpos_next = pick[2:0] + (paired ? 3'h2 : 3'h1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= '0;
      mode_reg   <= acs_pkg::ACS_SEQ_OFF;
      mask_reg   <= `ACS_MASK_RESET;
      armed_reg  <= 1'b0;
      seqpos_reg <= 3'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      mode_reg   <= mode_next;
      mask_reg   <= mask_next;
      armed_reg  <= armed_next;
      seqpos_reg <= seqpos_next;
    end
  end

  // conversion timing and outputs
  acs_pkg::acs_cv_e   cv_reg, cv_next;
  logic [3:0]         per_reg, per_next;
  logic               busy_next;
  logic               done_next;
  logic               abort_next;
  logic               conn_next;
  logic [2:0]         pos_next;
  logic [2:0]         neg_next;
  logic               gnd_next;
  logic [RES_BITS-1:0] result_next;
  acs_pkg::acs_ctrl_s ctrlo_next;
  logic               run_next;

  always_comb begin
    cv_next     = cv_reg;
    per_next    = per_reg;
    done_next   = 1'b0;
    abort_next  = 1'b0;
    pos_next    = pos_channel;
    neg_next    = neg_channel;
    gnd_next    = neg_is_ground;
    result_next = conv_result;
    ctrlo_next  = ctrl_reg;
    run_next    = (mode_reg != acs_pkg::ACS_SEQ_OFF);
    if (cv_reg == acs_pkg::ACS_CV_RUN && (cs_fall || wr_rise)) begin
      abort_next = 1'b1;
      cv_next    = acs_pkg::ACS_CV_IDLE;
    end
    case (cv_reg)
      acs_pkg::ACS_CV_IDLE: begin
        if (cs_fall) begin
          cv_next  = acs_pkg::ACS_CV_RUN;
          per_next = 4'h0;
          pos_next = chan;
          gnd_next = (ctrl_reg.input_config == `ACS_CFG_SINGLE);
          neg_next = neg_of(ctrl_reg.input_config, chan);
        end
      end
      acs_pkg::ACS_CV_RUN: begin
        if (cs_fall) begin
          // restart: partner input must follow the new channel
          cv_next  = acs_pkg::ACS_CV_RUN;
          per_next = 4'h0;
          pos_next = chan;
          gnd_next = (ctrl_reg.input_config == `ACS_CFG_SINGLE);
          neg_next = neg_of(ctrl_reg.input_config, chan);
        end else if (!wr_rise && ck_rise) begin
          per_next = per_reg + 4'h1;
          if (per_next == `ACS_CONV_PERIODS) begin
            cv_next   = acs_pkg::ACS_CV_IDLE;
            done_next = 1'b1;
            // one step is reference (or twice it) over 2**RES_BITS
            result_next = ctrl_reg.twos_complement ?
                          (sar_code ^ {1'b1, {(RES_BITS-1){1'b0}}}) : sar_code;
          end
        end
      end
      default: begin
        cv_next = acs_pkg::ACS_CV_IDLE;
      end
    endcase
    busy_next = (cv_next == acs_pkg::ACS_CV_RUN);
    conn_next = !busy_next;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cv_reg           <= acs_pkg::ACS_CV_IDLE;
      per_reg          <= 4'h0;
      conv_busy        <= 1'b0;
      conv_done        <= 1'b0;
      conv_aborted     <= 1'b0;
      inputs_connected <= 1'b1;
      pos_channel      <= 3'h0;
      neg_channel      <= 3'h0;
      neg_is_ground    <= 1'b1;
      conv_result      <= '0;
      ctrl_out         <= '0;
      seq_running      <= 1'b0;
    end else begin
      cv_reg           <= cv_next;
      per_reg          <= per_next;
      conv_busy        <= busy_next;
      conv_done        <= done_next;
      conv_aborted     <= abort_next;
      inputs_connected <= conn_next;
      pos_channel      <= pos_next;
      neg_channel      <= neg_next;
      neg_is_ground    <= gnd_next;
      conv_result      <= result_next;
      ctrl_out         <= ctrlo_next;
      seq_running      <= run_next;
    end
  end

endmodule
`default_nettype wire

// ### verif/acs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  input  wire logic        clk,
  output var  logic        write_strobe_n,
  output var  logic [11:0] data_lines,
  output var  logic        convert_start_n,
  output var  logic        conversion_clock_input
);
  initial begin
    write_strobe_n = 1'b1;
    data_lines = 12'h000;
    convert_start_n = 1'b1;
    conversion_clock_input = 1'b0;
  end
  // free-running, eight system cycles a period
  always begin
    repeat (4) @(posedge clk);
    conversion_clock_input <= ~conversion_clock_input;
  end
  task automatic put(input logic [11:0] word);
    @(posedge clk) data_lines <= word;
    repeat (3) @(posedge clk);
    write_strobe_n <= 1'b0;
    repeat (3) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (2) @(posedge clk);
    data_lines <= ~word;
    repeat (4) @(posedge clk);
  endtask
  task automatic start;
    @(posedge clk) convert_start_n <= 1'b0;
    repeat (3) @(posedge clk);
    convert_start_n <= 1'b1;
  endtask
  function automatic logic [7:0] mask_for(input logic [1:0] cfg, input logic [7:0] m);
    logic [7:0] e;
    e = (m | 8'h01) & 8'h55;
    if (cfg == 2'h1 || cfg == 2'h2) return e | (e << 1);
    if (cfg == 2'h3) return (m | 8'h01) & 8'h7f;
    return m | 8'h01;
  endfunction
endmodule
`default_nettype wire

// ### verif/acs_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_props #(
  parameter int RES_BITS = 12
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                convert_start_n,
  input wire logic                conversion_clock_input,
  input wire logic [RES_BITS-1:0] sar_code,
  input wire logic                inputs_connected,
  input wire logic                conv_busy,
  input wire logic                conv_done,
  input wire logic                conv_aborted,
  input wire logic [2:0]          pos_channel,
  input wire logic [2:0]          neg_channel,
  input wire logic                neg_is_ground,
  input wire logic [RES_BITS-1:0] conv_result,
  input wire acs_pkg::acs_ctrl_s  ctrl_out,
  input wire logic                seq_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] cnt_reg, cnt_next;
  logic       ck_reg, ck_next;
  // conversion clock rises seen while a conversion runs
  always_comb begin
    ck_next  = conversion_clock_input;
    cnt_next = (conv_busy && !conv_aborted) ? cnt_reg + 8'(ck_next & ~ck_reg) : 8'h00;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) {cnt_reg, ck_reg} <= 9'h000;
    else {cnt_reg, ck_reg} <= {cnt_next, ck_next};
  end
  sequence start_s;
    $fell(convert_start_n);
  endsequence
  sequence run_s;
    conv_busy && !inputs_connected;
  endsequence
  busy_isolated_a: assert property (conv_busy |-> !inputs_connected)
    else $error("inputs connected while busy");
  start_run_a: assert property (start_s |-> ##[1:5] run_s)
    else $error("no conversion after start");
  restart_abort_a: assert property (start_s ##0 conv_busy |-> ##[1:5] conv_aborted)
    else $error("no abort on restart");
  done_pulse_a: assert property (conv_done |->
    inputs_connected && !conv_busy ##1 !conv_done)
    else $error("bad completion pulse");
  period_count_a: assert property (conv_done |-> cnt_reg >= 8'h0b && cnt_reg <= 8'h0e)
    else $error("wrong period count");
  result_hold_a: assert property (!conv_done |-> $stable(conv_result))
    else $error("result moved");
  output_coding_a: assert property (conv_done && $stable(sar_code) |->
    conv_result == (ctrl_out.twos_complement ?
    {~sar_code[RES_BITS-1], sar_code[RES_BITS-2:0]} : sar_code))
    else $error("bad output coding");
  ground_select_a: assert property (conv_done |->
    neg_is_ground == (ctrl_out.input_config == 2'h0))
    else $error("bad ground select");
  pair_neg_a: assert property (conv_done && ctrl_out.input_config inside {2'h1, 2'h2}
    |-> neg_channel == (pos_channel ^ 3'h1))
    else $error("bad pair partner");
  common_neg_a: assert property (conv_done && ctrl_out.input_config == 2'h3
    |-> neg_channel == 3'h7)
    else $error("bad common input");
  pair_even_a: assert property (conv_done && seq_running &&
    ctrl_out.input_config inside {2'h1, 2'h2} |-> !pos_channel[0])
    else $error("swapped pair converted");
endmodule
bind acs_sequencer acs_sequencer_props #(.RES_BITS(RES_BITS)) i_props (.clk, .reset_n,
  .convert_start_n, .conversion_clock_input, .sar_code, .inputs_connected, .conv_busy,
  .conv_done, .conv_aborted, .pos_channel, .neg_channel, .neg_is_ground, .conv_result,
  .ctrl_out, .seq_running);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               write_strobe_n, convert_start_n, conversion_clock_input;
  logic [11:0]        data_lines, conv_result;
  logic [11:0]        sar_code = 12'h000;
  logic               inputs_connected, conv_busy, conv_done, conv_aborted;
  logic [2:0]         pos_channel, neg_channel;
  logic               neg_is_ground, seq_running, twos;
  acs_pkg::acs_ctrl_s ctrl_out;
  int                 err_count = 0;
  int                 checks_done = 0;
  int                 seed = 83064;
  int                 cur;
  logic [7:0]         sel;
  logic [1:0]         cfg;
  always #50 clk = ~clk;
  acs_host_model i_host (.clk, .write_strobe_n, .data_lines, .convert_start_n,
    .conversion_clock_input);
  acs_sequencer i_dut (.clk, .reset_n, .write_strobe_n, .data_lines, .convert_start_n,
    .conversion_clock_input, .sar_code, .inputs_connected, .conv_busy, .conv_done,
    .conv_aborted, .pos_channel, .neg_channel, .neg_is_ground, .conv_result, .ctrl_out,
    .seq_running);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic int nxt(input logic [7:0] s, input int c);
    for (int i = c + 1; i < 8; i++)
      if (s[i]) return i;
    for (int i = 0; i < 8; i++)
      if (s[i]) return i;
    return 0;
  endfunction
  task automatic run(input logic cut);
    int n;
    @(posedge clk) sar_code <= 12'($random(seed));
    i_host.start();
    if (cut) begin
      repeat (30) @(posedge clk);
      i_host.start();
      #1;
      chk({11'h000, conv_aborted}, 12'h001);
      cur = nxt(sel, cur);
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (conv_done !== 1'b1 && n < 400);
    chk({11'h000, conv_done}, 12'h001);
    if (conv_done !== 1'b1) report_and_stop();
    cur = nxt(sel, cur);
    chk({9'h000, pos_channel}, 12'(cur));
    chk(conv_result, twos ? {~sar_code[11], sar_code[10:0]} : sar_code);
    chk({11'h000, neg_is_ground}, {11'h000, cfg == 2'h0});
    if (cfg != 2'h0) chk({9'h000, neg_channel}, (cfg == 2'h3) ? 12'h007 : 12'(cur ^ 1));
  endtask
  initial begin
    logic [2:0]  adr;
    logic [11:0] w;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({3'h0, ctrl_out}, 12'h000);
    chk({10'h000, inputs_connected, neg_is_ground}, 12'h003);
    for (int t = 0; t < 4; t++) begin
      cfg = t[1:0];
      adr = 3'($random(seed));
      if (cfg == 2'h3 && adr == 3'h7) adr = 3'h6;
      w = 12'($random(seed));
      w = {1'b0, adr, cfg[0], cfg[1], w[5:4], 2'b01, w[1:0]};
      i_host.put(w);
      twos = w[0];
      chk({3'h0, ctrl_out}, {3'h0, w[5:4], cfg, w[1:0], adr});
      sel = i_host.mask_for(cfg, 8'($random(seed)));
      i_host.put({4'h0, sel});
      if (cfg == 2'h1 || cfg == 2'h2) sel = sel & 8'h55;
      cur = -1;
      chk({11'h000, seq_running}, 12'h001);
      for (int k = 0; k < 4; k++) run(k == 1);
      w[1:0] = ~w[1:0];
      w[3:2] = 2'b10;
      i_host.put(w);
      twos = w[0];
      run(1'b0);
      w[3:2] = 2'b11;
      i_host.put(w);
      sel = 8'((9'h002 << adr) - 9'h001);
      if (cfg == 2'h1 || cfg == 2'h2) sel = sel & 8'h55;
      cur = -1;
      run(1'b0);
      run(1'b0);
      w[3:2] = 2'b00;
      i_host.put(w);
      chk({11'h000, seq_running}, 12'h000);
      sel = 8'h01 << adr;
      run(1'b0);
      $display("test %0d done", t);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
